// ===== logic/sgf_stator_ground.sv
//
// Contract
// - adaptive pickup needs ratio, complement, supervision
// - each stage compares against own pickup
// - stage operates after own delay persists
// - stage blocked unless sum exceeds supervision
// - separate settings for stage one, two
// - neutral undervoltage picks up below threshold
// - threshold 0 to 3 pu, default 0.3
// - delay 0 to 600 s, 10 ms steps
// - power inside window inhibits undervoltage
// - lower setting is window lower edge
// - zero lower edge inhibits all below upper
// - terminal voltage must exceed supervision
`timescale 1ns/10ps
`default_nettype none
module sgf_stator_ground
	import sgf_pkg::*;
#(
	parameter int STEP_DIV = STEP_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        rst,
	// measured quantities, 0.001 pu
	input  wire logic [15:0] neutral_mag,
	input  wire logic [15:0] zero_seq_mag,
	input  wire logic [15:0] sum_mag,
	input  wire logic [15:0] terminal_power,
	input  wire logic [15:0] pos_seq_voltage,
	// adaptive stages, index 0 and 1
	input  wire logic [15:0] adaptive_stage_pickup [2],
	input  wire logic [15:0] adaptive_stage_delay [2],
	input  wire logic [15:0] adaptive_stage_supervision [2],
	// neutral undervoltage settings
	input  wire logic        neutral_uv_enable,
	input  wire logic [15:0] neutral_uv_threshold,
	input  wire logic [15:0] neutral_uv_delay,
	input  wire logic [15:0] inhibit_window_upper,
	input  wire logic [15:0] inhibit_window_lower,
	input  wire logic [15:0] terminal_voltage_supervision,
	input  wire logic        neutral_uv_block,
	input  wire logic [1:0]  neutral_uv_indication_mode,
	input  wire logic        neutral_uv_event_log_enable,
	input  wire logic        target_reset,
	output logic [1:0]       adaptive_pickup,
	output logic [1:0]       adaptive_operate,
	output logic             neutral_uv_pickup,
	output logic             neutral_uv_operate,
	output logic             neutral_uv_indication,
	output logic             neutral_uv_event
);
	////////////////////////////////////////////////////////////////
	// elaboration checks
	if (STEP_DIV < 1) begin : g_bad_div
		$error("step divider out of range");
	end
	if (UV_THR_RESET > UV_THR_MAX || VSUPV_RESET > VSUPV_MAX) begin : g_bad_reset
		$error("setting default above its limit");
	end
	if (UV_DLY_MAX == 16'h0000) begin : g_bad_dly
		$error("delay limit is zero");
	end

	////////////////////////////////////////////////////////////////
	// 10 ms step tick
	logic [31:0] div_cnt;
	logic        tick;

	always_ff @(posedge clock) begin
		if (rst || div_cnt == 32'(STEP_DIV - 1)) begin
			div_cnt <= 32'h00000000;
		end else begin
			div_cnt <= div_cnt + 32'h00000001;
		end
	end
	assign tick = (div_cnt == 32'(STEP_DIV - 1));

	////////////////////////////////////////////////////////////////
	// adaptive stages
	logic [31:0] lhs_n;
	logic [31:0] lhs_z;
	logic [1:0]  stage_cond;

	assign lhs_n = 32'(neutral_mag) * 32'(PU_ONE);
	assign lhs_z = 32'(zero_seq_mag) * 32'(PU_ONE);

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_stage
			logic [31:0] rhs_p;
			logic [31:0] rhs_c;
			logic [15:0] one_minus;
			logic        ratio_low;
			logic        comp_high;
			logic        supv_ok;
			sgf_tmr_if   st ();

			assign one_minus = (adaptive_stage_pickup[g] > PU_ONE) ? 16'h0000
			                   : PU_ONE - adaptive_stage_pickup[g];
			assign rhs_p = 32'(sum_mag) * 32'(adaptive_stage_pickup[g]);
			assign rhs_c = 32'(sum_mag) * 32'(one_minus);
			// ratio test done by cross-multiplying with the sum
			assign ratio_low     = (lhs_n < rhs_p);
			assign comp_high     = (lhs_z > rhs_c);
			assign supv_ok       = (sum_mag > adaptive_stage_supervision[g]);
			assign stage_cond[g] = ratio_low && comp_high && supv_ok;
			assign st.cond  = stage_cond[g];
			assign st.clear = 1'b0;
			assign st.delay = adaptive_stage_delay[g];
			assign st.tick  = tick;

			// per stage delay timer
			sgf_delay_timer u_tmr (
				.clock (clock),
				.rst   (rst),
				.t     (st)
			);

			always_ff @(posedge clock) begin
				if (rst) begin
					adaptive_pickup[g]  <= 1'b0;
					adaptive_operate[g] <= 1'b0;
				end else begin
					adaptive_pickup[g]  <= stage_cond[g];
					adaptive_operate[g] <= st.operate && stage_cond[g];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// neutral undervoltage
	logic        uv_active;
	logic        mode_off;
	logic        uv_blocked;
	logic        above_lower;
	logic        below_upper;
	logic        in_window;
	logic        uv_low;
	logic        volt_ok;
	logic        uv_cond;
	logic [15:0] thr_eff;
	logic [15:0] dly_eff;
	logic        uv_op;
	logic        uv_op_d;
	logic        op_rise;
	logic        ind_clear;
	sgf_tmr_if   ut ();

	// threshold and delay settings beyond their range saturate
	assign thr_eff = (neutral_uv_threshold > UV_THR_MAX) ? UV_THR_MAX
	                 : neutral_uv_threshold;
	assign dly_eff = (neutral_uv_delay > UV_DLY_MAX) ? UV_DLY_MAX
	                 : neutral_uv_delay;
	assign mode_off   = (neutral_uv_indication_mode == SGF_TGT_DISABLED);
	assign uv_active  = neutral_uv_enable && !mode_off;
	assign uv_blocked = neutral_uv_block || !uv_active;

	// zero lower edge includes every power under the upper limit
	assign above_lower = (inhibit_window_lower == 16'h0000)
	                     || (terminal_power > inhibit_window_lower);
	assign below_upper = (terminal_power < inhibit_window_upper);
	assign in_window   = above_lower && below_upper;

	assign uv_low  = (neutral_mag < thr_eff);
	assign volt_ok = (pos_seq_voltage > terminal_voltage_supervision);
	assign uv_cond = !uv_blocked && uv_low && !in_window && volt_ok;

	////////////////////////////////////////////////////////////////
	// undervoltage delay timer
	assign ut.cond  = uv_cond;
	assign ut.clear = uv_blocked;
	assign ut.delay = dly_eff;
	assign ut.tick  = tick;

	sgf_delay_timer u_uv_tmr (
		.clock (clock),
		.rst   (rst),
		.t     (ut)
	);

	// operate drops with the condition
	assign uv_op   = ut.operate && uv_cond;
	assign op_rise = uv_op && !uv_op_d;

	always_ff @(posedge clock) begin
		if (rst) begin
			neutral_uv_pickup  <= 1'b0;
			neutral_uv_operate <= 1'b0;
			uv_op_d            <= 1'b0;
		end else begin
			neutral_uv_pickup  <= uv_cond;
			neutral_uv_operate <= uv_op;
			uv_op_d            <= uv_op;
		end
	end

	////////////////////////////////////////////////////////////////
	// indication: self-reset follows operate, latched holds until reset or until uv_active drops (neutral_uv_enable low or mode disabled)
	assign ind_clear = (neutral_uv_indication_mode == SGF_TGT_SELF_RESET) || target_reset;

	always_ff @(posedge clock) begin
		if (rst || !uv_active) begin
			neutral_uv_indication <= 1'b0;
		end else if (uv_op) begin
			neutral_uv_indication <= 1'b1;
		end else if (ind_clear) begin
			neutral_uv_indication <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// one-cycle event on operate rising edge
	always_ff @(posedge clock) begin
		if (rst) begin
			neutral_uv_event <= 1'b0;
		end else begin
			neutral_uv_event <= neutral_uv_event_log_enable && op_rise;
		end
	end
endmodule : sgf_stator_ground
`default_nettype wire

// ===== logic/sgf_pkg.sv
package sgf_pkg;
	// fixed point: per unit values in thousandths (0.001 pu)
	localparam int          PU_W            = 16;
	localparam logic [15:0] PU_ONE          = 16'h03e8;
	localparam logic [15:0] UV_THR_MAX      = 16'h0bb8;
	localparam logic [15:0] UV_THR_RESET    = 16'h012c;
	localparam logic [15:0] WIN_UPPER_RESET = 16'h00c8;
	localparam logic [15:0] WIN_LOWER_RESET = 16'h00c8;
	localparam logic [15:0] VSUPV_MAX       = 16'h04e2;
	localparam logic [15:0] VSUPV_RESET     = 16'h01f4;
	// delays in 0.01 s steps
	localparam int          DLY_W           = 16;
	localparam logic [15:0] UV_DLY_MAX      = 16'hea60;
	localparam int          CLK_HZ          = 40000000;
	localparam int          STEP_MS         = 10;
	localparam int          STEP_CYCLES     = CLK_HZ / 1000 * STEP_MS;
	typedef enum logic [1:0] {
		SGF_TGT_SELF_RESET,
		SGF_TGT_LATCHED,
		SGF_TGT_DISABLED
	} sgf_target_e;
	typedef enum {
		SGF_IDLE,
		SGF_TIMING,
		SGF_OPERATE
	} sgf_tmr_e;
endpackage : sgf_pkg

// ===== logic/sgf_tmr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sgf_tmr_if;
	logic        cond;
	logic        clear;
	logic [15:0] delay;
	logic        tick;
	logic        operate;
	modport ctrl (output cond, output clear, output delay, output tick, input operate);
	modport tmr  (input cond, input clear, input delay, input tick, output operate);
endinterface : sgf_tmr_if
`default_nettype wire

// ===== logic/sgf_delay_timer.sv
`timescale 1ns/10ps
`default_nettype none
module sgf_delay_timer
	import sgf_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst,
	sgf_tmr_if.tmr    t
);
	sgf_tmr_e    state;
	logic [15:0] count;

	// pickup must persist for delay steps before operate
	always_ff @(posedge clock) begin
		if (rst || t.clear || !t.cond) begin
			state <= SGF_IDLE;
			count <= 16'h0000;
		end else begin
			unique case (state)
				SGF_IDLE: begin
					if (t.delay == 16'h0000) begin
						state <= SGF_OPERATE;
					end else begin
						state <= SGF_TIMING;
						count <= 16'h0000;
					end
				end
				SGF_TIMING: begin
					if (t.tick) begin
						if (count + 16'h0001 >= t.delay) begin
							state <= SGF_OPERATE;
						end
						count <= count + 16'h0001;
					end
				end
				SGF_OPERATE: begin
					state <= SGF_OPERATE;
				end
			endcase
		end
	end

	assign t.operate = (state == SGF_OPERATE);
endmodule : sgf_delay_timer
`default_nettype wire

// ===== test/sgf_front_end.sv
`timescale 1ns/10ps
`default_nettype none
module sgf_front_end (
	input  wire logic        clock,
	input  wire logic [15:0] req [5],
	output logic      [15:0] meas [5]
);
	// one frame of measurement latency
	always_ff @(posedge clock) begin
		meas <= req;
	end
endmodule : sgf_front_end
`default_nettype wire

// ===== test/sgf_chk_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module sgf_chk
	import sgf_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [15:0] neutral_mag,
	input wire logic [15:0] zero_seq_mag,
	input wire logic [15:0] sum_mag,
	input wire logic [15:0] terminal_power,
	input wire logic [15:0] pos_seq_voltage,
	input wire logic [15:0] adaptive_stage_pickup [2],
	input wire logic [15:0] adaptive_stage_supervision [2],
	input wire logic neutral_uv_enable,
	input wire logic [15:0] neutral_uv_threshold,
	input wire logic [15:0] neutral_uv_delay,
	input wire logic [15:0] inhibit_window_upper,
	input wire logic [15:0] inhibit_window_lower,
	input wire logic [15:0] terminal_voltage_supervision,
	input wire logic neutral_uv_block,
	input wire logic [1:0] neutral_uv_indication_mode,
	input wire logic neutral_uv_event_log_enable,
	input wire logic target_reset,
	input wire logic [1:0] adaptive_pickup,
	input wire logic [1:0] adaptive_operate,
	input wire logic neutral_uv_pickup,
	input wire logic neutral_uv_operate,
	input wire logic neutral_uv_indication,
	input wire logic neutral_uv_event
);
	logic [1:0] ac;
	logic       inh, off, uvc;
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			ac[i] = 32'(neutral_mag) * 1000 < 32'(adaptive_stage_pickup[i]) * sum_mag
				&& 32'(zero_seq_mag) * 1000 > 32'(adaptive_stage_pickup[i] > PU_ONE ? 16'h0000
				: PU_ONE - adaptive_stage_pickup[i]) * sum_mag
				&& sum_mag > adaptive_stage_supervision[i];
		end
		inh = (inhibit_window_lower == 0 || terminal_power > inhibit_window_lower)
			&& terminal_power < inhibit_window_upper;
		off = !neutral_uv_enable || neutral_uv_indication_mode == 2'h2 || neutral_uv_block;
		uvc = !off && !inh && pos_seq_voltage > terminal_voltage_supervision
			&& neutral_mag < (neutral_uv_threshold > UV_THR_MAX ? UV_THR_MAX
			: neutral_uv_threshold);
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	property p_uv; 1 |=> neutral_uv_pickup == $past(uvc); endproperty
	a_uv: assert property (p_uv) else $error("uv pickup wrong");
	property p_inh; inh |=> !neutral_uv_pickup; endproperty
	a_inh: assert property (p_inh) else $error("uv pickup in window");
	property p_blk; neutral_uv_block |=> !neutral_uv_pickup && !neutral_uv_operate; endproperty
	a_blk: assert property (p_blk) else $error("uv active while blocked");
	property p_dis; (!neutral_uv_enable || neutral_uv_indication_mode == 2'h2)
		|=> !(neutral_uv_pickup || neutral_uv_operate || neutral_uv_indication); endproperty
	a_dis: assert property (p_dis) else $error("uv active while disabled");
	property p_lat; neutral_uv_indication && neutral_uv_indication_mode == 2'h1
		&& !target_reset && !off |=> neutral_uv_indication; endproperty
	a_lat: assert property (p_lat) else $error("latched indication lost");
	property p_d0; neutral_uv_delay == 0 && uvc ##1 uvc |=> neutral_uv_operate; endproperty
	a_d0: assert property (p_d0) else $error("uv operate late");
	property p_uop; neutral_uv_operate |-> neutral_uv_pickup; endproperty
	a_uop: assert property (p_uop) else $error("uv operate without pickup");
	property p_ad; 1 |=> adaptive_pickup == $past(ac); endproperty
	a_ad: assert property (p_ad) else $error("stage pickup wrong");
	property p_aop; (adaptive_operate & ~adaptive_pickup) == 2'h0; endproperty
	a_aop: assert property (p_aop) else $error("stage operate without pickup");
	property p_ev; neutral_uv_event
		== ($rose(neutral_uv_operate) && $past(neutral_uv_event_log_enable)); endproperty
	a_ev: assert property (p_ev) else $error("uv event wrong");
	c_ev: cover property (neutral_uv_event);
	c_aop: cover property (adaptive_operate[0]);
	c_uop: cover property (neutral_uv_operate);
	c_lat: cover property (neutral_uv_indication && !neutral_uv_operate);
endmodule : sgf_chk
bind sgf_stator_ground sgf_chk u_chk (.*);
`default_nettype wire

// ===== test/test_sgf_stator_ground.sv
`timescale 1ns/10ps
`default_nettype none
module test_sgf_stator_ground;
	import sgf_pkg::*;
	logic        clock = 0, rst = 1, en = 1, blk = 0, tr = 0, ev = 0, upk, uop, uind, uev;
	logic [1:0]  mode = 0, ap, ao;
	logic [15:0] req [5], meas [5], pk [2], dl [2], sv [2];
	logic [15:0] thr = 0, udl = 0, up = 0, lo = 0, vs = 0;
	int          err_count = 0, num_checks = 0, cyc = 0, n, ev_cnt = 0, ev_base = 0;
	always #12.5 clock = ~clock;
	sgf_front_end fe_u (.clock(clock), .req(req), .meas(meas));
	sgf_stator_ground #(.STEP_DIV(4)) dut_u (.clock(clock), .rst(rst), .neutral_mag(meas[0]),
		.zero_seq_mag(meas[1]), .sum_mag(meas[2]), .terminal_power(meas[3]),
		.pos_seq_voltage(meas[4]), .adaptive_stage_pickup(pk), .adaptive_stage_delay(dl),
		.adaptive_stage_supervision(sv), .neutral_uv_enable(en), .neutral_uv_threshold(thr),
		.neutral_uv_delay(udl), .inhibit_window_upper(up), .inhibit_window_lower(lo),
		.terminal_voltage_supervision(vs), .neutral_uv_block(blk),
		.neutral_uv_indication_mode(mode), .neutral_uv_event_log_enable(ev),
		.target_reset(tr), .adaptive_pickup(ap), .adaptive_operate(ao),
		.neutral_uv_pickup(upk), .neutral_uv_operate(uop), .neutral_uv_indication(uind),
		.neutral_uv_event(uev));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish
	task automatic step(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : step
	function automatic logic [15:0] f_ad();
		f_ad = 0;
		for (int i = 0; i < 2; i++) begin
			f_ad[i] = 32'(meas[0]) * 1000 < 32'(pk[i]) * meas[2] && meas[2] > sv[i]
				&& 32'(meas[1]) * 1000 > 32'(pk[i] > 1000 ? 0 : 1000 - pk[i]) * meas[2];
		end
	endfunction : f_ad
	function automatic logic f_uv();
		logic inh;
		inh = (lo == 0 || meas[3] > lo) && meas[3] < up;
		return en && mode != 2 && !blk && !inh && meas[4] > vs
			&& meas[0] < (thr > UV_THR_MAX ? UV_THR_MAX : thr);
	endfunction : f_uv
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (uev === 1'b1) ev_cnt <= ev_cnt + 1;
		if (cyc == 5000) begin
			err_count++;
			tally_and_finish();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		req = '{default: 0};
		pk = '{default: 0};
		sv = '{default: 0};
		dl = '{16'h0003, 16'h0000};
		void'($urandom(63025));
		repeat (20) @(posedge clock);
		rst <= 0;
		// random settings and measurements
		for (int k = 0; k < 300; k++) begin
			@(posedge clock);
			foreach (req[j]) req[j] <= 16'($urandom % (j == 0 ? 3600 : 1600));
			pk <= '{16'($urandom % 1100), 16'($urandom % 1100)};
			sv <= '{16'($urandom % 1600), 16'($urandom % 1600)};
			en <= $urandom % 4 != 0;
			blk <= $urandom % 4 == 0;
			ev <= 1'($urandom % 2);
			mode <= 2'($urandom % 3);
			thr <= 16'($urandom % 4000);
			lo <= $urandom % 3 == 0 ? 16'h0000 : 16'($urandom % 800);
			up <= 16'($urandom % 1250);
			vs <= 16'($urandom % 1250);
			step(3);
			check(16'(ap), f_ad(), "stage pickup");
			check(16'(upk), 16'(f_uv()), "uv pickup");
		end
		// steady fault, latched indication
		@(posedge clock);
		req <= '{default: 0};
		{en, blk, ev, mode, udl} <= {1'b1, 1'b0, 1'b1, 2'h1, 16'h0002};
		{thr, lo, up, vs} <= {16'h012c, 16'h00c8, 16'h04e2, 16'h01f4};
		pk <= '{16'h01f4, 16'h01f4};
		sv <= '{16'h01f4, 16'h01f4};
		step(3);
		ev_base = ev_cnt;
		req <= '{16'h0064, 16'h0384, 16'h03e8, 16'h0000, 16'h03e8};
		step(3);
		check(16'(ao), 16'h0002, "stage operate");
		for (n = 0; n < 20 && ao[0] !== 1'b1; n++) step(1);
		check(16'(n >= 8 && n <= 13), 16'h0001, "stage delay");
		check(16'({uop, uind}), 16'h0003, "uv operate");
		check(16'(ev_cnt - ev_base), 16'h0001, "uv event");
		req[0] <= 16'h03e8;
		step(3);
		check(16'({uop, uind}), 16'h0001, "uv latched");
		tr <= 1;
		step(2);
		check(16'(uind), 16'h0000, "uv target reset");
		tr <= 0;
		tally_and_finish();
	end
endmodule : test_sgf_stator_ground
`default_nettype wire
